// File: rtl/iodsc_pkg.sv
// Package for the I/O decode and instruction/data split control block.
// Assumes a 32-bit APB register bus and a single system clock domain.
package iodsc_pkg;

  // Register offset and layout of the control register.
  localparam logic [11:0] IODSC_CTRL_OFFSET = 12'h010;
  localparam int IODSC_CTRL_WIDTH = 8;
  localparam logic [7:0] IODSC_CTRL_RESET = 8'h00;
  localparam logic [7:0] IODSC_CTRL_WMASK = 8'hbf;

  // Bit positions inside the control register.
  localparam int IODSC_BIT_WIDE_IO = 7;
  localparam int IODSC_BIT_RSVD = 6;
  localparam int IODSC_BIT_DATA_ONLY = 5;
  localparam int IODSC_BIT_FORCE_CS1 = 4;
  localparam int IODSC_BIT_DSEG_A19 = 3;
  localparam int IODSC_BIT_DSEG_A16 = 2;
  localparam int IODSC_BIT_ROOT_A19 = 1;
  localparam int IODSC_BIT_ROOT_A16 = 0;

  // Internal I/O address widths and the narrow-mode mask.
  localparam int IODSC_IO_ADDR_W = 16;
  localparam logic [15:0] IODSC_NARROW_MASK = 16'h00ff;

  // Physical address width and the two bits that may be inverted.
  localparam int IODSC_PHYS_W = 20;
  localparam int IODSC_A16 = 16;
  localparam int IODSC_A19 = 19;

  // Per-access qualifiers from the segment decoder and sequencer.
  typedef struct packed {
    logic rootSeg;
    logic data_segment;
    logic dataAccess;
  } iodsc_qual_t;

  // Decoded control fields.
  typedef struct packed {
    logic wideIo;
    logic dataOnly;
    logic forceCs1;
    logic dsegA19;
    logic dsegA16;
    logic rootA19;
    logic rootA16;
  } iodsc_ctrl_t;

endpackage

// File: rtl/iodsc_addr_mod.sv
// Address modifier: inverts A16/A19 per segment and control fields.
// Assumes qualifiers are valid together with the physical address.
`timescale 1ns/1ps
module iodsc_addr_mod (
  // Control and qualifiers.
  input wire iodsc_pkg::iodsc_ctrl_t ctrl,
  input wire iodsc_pkg::iodsc_qual_t qual,
  // Addresses.
  input wire logic [iodsc_pkg::IODSC_PHYS_W-1:0] physAddr,
  output logic [iodsc_pkg::IODSC_PHYS_W-1:0] modAddr
);
  import iodsc_pkg::*;

  logic qualifies;
  logic invA16;
  logic invA19;

  // In split mode only data accesses qualify; otherwise every access does.
  assign qualifies = !ctrl.dataOnly || qual.dataAccess;

  // Pick the inversion for the segment the access falls into.
  assign invA16 = qualifies && ((qual.data_segment && ctrl.dsegA16) ||
                  (qual.rootSeg && ctrl.rootA16));
  assign invA19 = qualifies && ((qual.data_segment && ctrl.dsegA19) ||
                  (qual.rootSeg && ctrl.rootA19));

  // Apply the inversions ahead of the bank select decision.
  always_comb begin
    modAddr = physAddr;
    modAddr[IODSC_A16] = physAddr[IODSC_A16] ^ invA16;
    modAddr[IODSC_A19] = physAddr[IODSC_A19] ^ invA19;
  end

endmodule

// File: rtl/iodsc_top.sv
// Top of the I/O decode and instruction/data split control block.
// Assumes an APB master on sys_clk and qualifiers from the same clock.
//
// Summary of operation
// - Reset leaves narrow eight-bit internal I/O decoding selected.
// - Bit 7 clear: decode internal I/O from low eight address bits.
// - Bit 7 set: decode the full internal I/O address width.
// - Bit 6 ignores writes and always reads zero.
// - Bit 5 clear: inversions apply to fetches and data accesses alike.
// - Bit 5 set: inversions apply to data accesses only.
// - Bit 4 set forces the first memory chip select active.
// - Bit 3 set inverts A19 on data-segment accesses before bank select.
// - Bit 2 set inverts A16 on data-segment accesses.
// - Bit 1 set inverts A19 on root-segment accesses before bank select.
// - Bit 0 set inverts A16 on root-segment accesses.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module iodsc_top (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_b,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Internal I/O decode.
  input wire logic [iodsc_pkg::IODSC_IO_ADDR_W-1:0] ioAddr,
  output logic [iodsc_pkg::IODSC_IO_ADDR_W-1:0] ioDecodeAddr,
  // Memory path.
  input wire iodsc_pkg::iodsc_qual_t accessQual,
  input wire logic [iodsc_pkg::IODSC_PHYS_W-1:0] physAddr,
  output logic [iodsc_pkg::IODSC_PHYS_W-1:0] bankAddr,
  input wire logic memoryChipSelectOneReq_n,
  output logic memoryChipSelectOne_n
);
  import iodsc_pkg::*;

  logic [IODSC_CTRL_WIDTH-1:0] ctrl_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic [IODSC_PHYS_W-1:0] bankAddr_reg;
  logic [IODSC_PHYS_W-1:0] modAddr;
  logic [IODSC_IO_ADDR_W-1:0] ioDecode_reg;
  logic cs1_reg;
  logic apbAccess;
  logic hitCtrl;
  iodsc_ctrl_t ctrlFields;

  // Word-aligned register decode, used for reads and writes alike.
  function automatic logic isCtrl(input logic [11:0] addr);
    isCtrl = (addr[11:2] == IODSC_CTRL_OFFSET[11:2]);
  endfunction

  // The slave answers in the first access cycle, with no wait states.
  assign apbAccess = psel && penable;
  assign hitCtrl = isCtrl(paddr);
  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;

  // Control register write; bit 6 is masked off so it stays zero.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= IODSC_CTRL_RESET;
    end else if (apbAccess && pwrite && hitCtrl) begin
      ctrl_reg <= pwdata[7:0] & IODSC_CTRL_WMASK;
    end
  end

  // Read data is captured during setup so it is registered in access phase.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= hitCtrl ? {24'h00_0000, ctrl_reg} : 32'h0000_0000;
    end
  end

  // Unmapped addresses get an error answer; nothing is written.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pslverr_reg <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_reg <= !hitCtrl;
    end
  end

  // Split the register into named fields.
  assign ctrlFields.wideIo = ctrl_reg[IODSC_BIT_WIDE_IO];
  assign ctrlFields.dataOnly = ctrl_reg[IODSC_BIT_DATA_ONLY];
  assign ctrlFields.forceCs1 = ctrl_reg[IODSC_BIT_FORCE_CS1];
  assign ctrlFields.dsegA19 = ctrl_reg[IODSC_BIT_DSEG_A19];
  assign ctrlFields.dsegA16 = ctrl_reg[IODSC_BIT_DSEG_A16];
  assign ctrlFields.rootA19 = ctrl_reg[IODSC_BIT_ROOT_A19];
  assign ctrlFields.rootA16 = ctrl_reg[IODSC_BIT_ROOT_A16];

  // Internal I/O decode address, narrow or wide by bit 7.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ioDecode_reg <= '0;
    end else if (ctrlFields.wideIo) begin
      ioDecode_reg <= ioAddr;
    end else begin
      ioDecode_reg <= ioAddr & IODSC_NARROW_MASK;
    end
  end
  assign ioDecodeAddr = ioDecode_reg;

  // Segment inversions, driven by per-access qualifiers.
  iodsc_addr_mod u_addr_mod (
    .ctrl(ctrlFields),
    .qual(accessQual),
    .physAddr(physAddr),
    .modAddr(modAddr)
  );

  // Registered bank-select address.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bankAddr_reg <= '0;
    end else begin
      bankAddr_reg <= modAddr;
    end
  end
  assign bankAddr = bankAddr_reg;

  // First memory chip select, forced low while bit 4 is set.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cs1_reg <= 1'b1;
    end else begin
      cs1_reg <= ctrlFields.forceCs1 ? 1'b0 : memoryChipSelectOneReq_n;
    end
  end
  assign memoryChipSelectOne_n = cs1_reg;

  // Bit 6 never holds a one.
  rsvd_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ctrl_reg[IODSC_BIT_RSVD] == 1'b0) else $error("reserved bit set");

  // A write reaches the register one edge later, bit 6 masked.
  ctrl_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (apbAccess && pwrite && hitCtrl) |=> ctrl_reg == ($past(pwdata[7:0]) & 8'hbf))
    else $error("control write lost");

  // Narrow mode clears the upper decode bits.
  narrow_decode_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !ctrlFields.wideIo |=> ioDecodeAddr[15:8] == 8'h00 && ioDecodeAddr[7:0] == $past(ioAddr[7:0]))
    else $error("narrow decode wrong");

  // Wide mode passes the full address.
  wide_decode_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ctrlFields.wideIo |=> ioDecodeAddr == $past(ioAddr)) else $error("wide decode wrong");

  // Forced chip select stays low while forced.
  force_cs_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ctrlFields.forceCs1 |=> !memoryChipSelectOne_n) else $error("cs1 not forced");

  // Fetches in split mode pass unchanged.
  split_fetch_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ctrlFields.dataOnly && !accessQual.dataAccess) |=> bankAddr == $past(physAddr))
    else $error("fetch address altered");

  // Root A16 inversion when every access qualifies.
  root_a16_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!ctrlFields.dataOnly && accessQual.rootSeg && !accessQual.data_segment && ctrlFields.rootA16)
    |=> bankAddr[16] != $past(physAddr[16])) else $error("root A16 not inverted");

  // Data A19 inversion on a qualifying data access.
  dseg_a19_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (accessQual.data_segment && !accessQual.rootSeg && accessQual.dataAccess && ctrlFields.dsegA19)
    |=> bankAddr[19] != $past(physAddr[19])) else $error("data A19 not inverted");

  // A setup cycle followed by the write access to the control register.
  sequence ctrl_write_s;
    (psel && !penable && pwrite && hitCtrl) ##1 (apbAccess && pwrite && hitCtrl);
  endsequence

  // A read setup cycle to any address.
  sequence read_setup_s;
    psel && !penable && !pwrite;
  endsequence

  // A setup cycle to an address that holds no register.
  sequence unmapped_setup_s;
    psel && !penable && !hitCtrl;
  endsequence

  // An access that falls in the root segment alone.
  sequence root_only_s;
    accessQual.rootSeg && !accessQual.data_segment;
  endsequence

  // An access that falls in the data segment alone.
  sequence data_seg_only_s;
    accessQual.data_segment && !accessQual.rootSeg;
  endsequence

  // The decode mode bit follows a completed write.
  write_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ctrl_write_s
    |=> ctrl_reg[IODSC_BIT_WIDE_IO] == $past(pwdata[7])) else $error("mode bit not written");

  // The low control bits follow a completed write.
  write_low_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ctrl_write_s
    |=> ctrl_reg[5:0] == $past(pwdata[5:0])) else $error("low control bits not written");

  // An unmapped address is answered with an error.
  unmapped_err_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    unmapped_setup_s
    |=> pslverr) else $error("unmapped access not flagged");

  // The control register is answered without an error.
  mapped_ok_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (psel && !penable && hitCtrl)
    |=> !pslverr) else $error("mapped access flagged");

  // A read of the control register returns its value in the low byte.
  read_value_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (read_setup_s ##0 hitCtrl)
    |=> prdata == {24'h00_0000, $past(ctrl_reg)}) else $error("read data wrong");

  // The upper read bytes are always zero.
  read_upper_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    read_setup_s
    |=> prdata[31:8] == 24'h00_0000) else $error("upper read bytes set");

  // Bit 6 reads as zero.
  read_rsvd_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    read_setup_s
    |=> prdata[IODSC_BIT_RSVD] == 1'b0) else $error("reserved bit read as one");

  // An unmapped read returns zero.
  unmapped_read_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (unmapped_setup_s ##0 !pwrite)
    |=> prdata == 32'h0000_0000) else $error("unmapped read not zero");

  // An unmapped write leaves the control register alone.
  unmapped_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (apbAccess && pwrite && !hitCtrl)
    |=> $stable(ctrl_reg)) else $error("unmapped write changed control");

  // Without an access the control register holds its value.
  idle_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !apbAccess
    |=> $stable(ctrl_reg)) else $error("control changed without access");

  // Read data only changes after a setup cycle.
  prdata_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !(psel && !penable)
    |=> $stable(prdata)) else $error("read data changed outside setup");

  // The error answer only changes after a setup cycle.
  err_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !(psel && !penable)
    |=> $stable(pslverr)) else $error("error answer changed outside setup");

  // Wide mode lets upper internal I/O address bits through.
  wide_reach_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ctrlFields.wideIo && ioAddr[15:8] != 8'h00)
    |=> ioDecodeAddr[15:8] != 8'h00) else $error("wide decode lost upper bits");

  // Data A16 inversion on a qualifying data access.
  dseg_a16_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (data_seg_only_s ##0 (accessQual.dataAccess && ctrlFields.dsegA16))
    |=> bankAddr[16] != $past(physAddr[16])) else $error("data A16 not inverted");

  // Data A16 passes when its bit is clear.
  dseg_a16_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (data_seg_only_s ##0 !ctrlFields.dsegA16)
    |=> bankAddr[16] == $past(physAddr[16])) else $error("data A16 altered");

  // Data A19 passes when its bit is clear.
  dseg_a19_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (data_seg_only_s ##0 !ctrlFields.dsegA19)
    |=> bankAddr[19] == $past(physAddr[19])) else $error("data A19 altered");

  // Root A19 inversion when every access qualifies.
  root_a19_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (root_only_s ##0 (!ctrlFields.dataOnly && ctrlFields.rootA19))
    |=> bankAddr[19] != $past(physAddr[19])) else $error("root A19 not inverted");

  // Root A19 passes when its bit is clear.
  root_a19_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (root_only_s ##0 !ctrlFields.rootA19)
    |=> bankAddr[19] == $past(physAddr[19])) else $error("root A19 altered");

  // Root A16 passes when its bit is clear.
  root_a16_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (root_only_s ##0 !ctrlFields.rootA16)
    |=> bankAddr[16] == $past(physAddr[16])) else $error("root A16 altered");

  // A fetch is inverted too while split mode is off.
  all_access_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (root_only_s ##0 (!ctrlFields.dataOnly && !accessQual.dataAccess && ctrlFields.rootA19))
    |=> bankAddr[19] != $past(physAddr[19])) else $error("fetch not inverted");

  // A data access is still inverted in split mode.
  split_data_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (root_only_s ##0 (ctrlFields.dataOnly && accessQual.dataAccess && ctrlFields.rootA16))
    |=> bankAddr[16] != $past(physAddr[16])) else $error("split data not inverted");

  // Both segment flags combine the two A16 enables.
  both_seg_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (accessQual.rootSeg && accessQual.data_segment && !ctrlFields.dataOnly)
    |=> bankAddr[16] == ($past(physAddr[16]) ^ ($past(ctrl_reg[0]) || $past(ctrl_reg[2]))))
    else $error("combined A16 wrong");

  // An access outside both segments passes unchanged.
  no_seg_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!accessQual.rootSeg && !accessQual.data_segment)
    |=> bankAddr == $past(physAddr)) else $error("unsegmented address altered");

  // The low address bits are never touched.
  low_bits_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    1'b1
    |=> bankAddr[15:0] == $past(physAddr[15:0])) else $error("low address bits altered");

  // The bits between A16 and A19 are never touched.
  mid_bits_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    1'b1
    |=> bankAddr[18:17] == $past(physAddr[18:17])) else $error("middle address bits altered");

  // The chip select follows its request while not forced.
  cs_pass_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !ctrlFields.forceCs1
    |=> memoryChipSelectOne_n == $past(memoryChipSelectOneReq_n)) else $error("cs1 not passed");

  // An idle request keeps the chip select inactive while not forced.
  cs_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!ctrlFields.forceCs1 && memoryChipSelectOneReq_n)
    |=> memoryChipSelectOne_n) else $error("cs1 active without request");

endmodule

// File: bench/iodsc_top_tb_top.sv
// Self-checking testbench for the I/O decode and instruction/data split control block.
// Assumes the block answers APB at once and registers its datapath outputs one cycle late.
`timescale 1ns/1ps
module iodsc_top_tb_top;
  import iodsc_pkg::*;
  typedef struct {int due; logic [15:0] io; logic [19:0] ba; logic cs;} iodsc_dp_t;
  typedef struct {logic rd; logic err; logic [31:0] d;} iodsc_ap_t;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic csReq_n = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cs_n;
  logic [15:0] ioAddr = 16'h0;
  logic [15:0] ioDec;
  logic [19:0] physAddr = 20'h0;
  logic [19:0] bankAddr;
  iodsc_qual_t qual = '0;
  logic [7:0] ctrl = 8'h00;
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  iodsc_dp_t dpQ[$];
  iodsc_ap_t apQ[$];

  iodsc_top i_iodsc_top (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ioAddr(ioAddr), .ioDecodeAddr(ioDec), .accessQual(qual),
    .physAddr(physAddr), .bankAddr(bankAddr), .memoryChipSelectOneReq_n(csReq_n),
    .memoryChipSelectOne_n(cs_n));

  // The clock toggles every half period of 2.5 ns.
  always #2.5 sys_clk = ~sys_clk;

  // Compares one value and counts the outcome.
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("Checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // One APB transfer; the expected answer is noted before the access phase.
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    int n;
    logic err;
    n = 0;
    err = a != IODSC_CTRL_OFFSET;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    apQ.push_back('{!wr, err, err ? 32'h0 : {24'h0, ctrl}});
    if (wr && !err) ctrl = d[7:0] & 8'hbf;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      results();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Drives one memory and I/O access and notes the modified outputs it must yield.
  task automatic dp(logic [15:0] io, logic [19:0] pa, logic [2:0] q, logic req);
    logic inv;
    @(posedge sys_clk);
    ioAddr <= io;
    physAddr <= pa;
    qual <= iodsc_qual_t'(q);
    csReq_n <= req;
    inv = !ctrl[5] || q[0];
    pa[16] ^= inv && ((q[2] && ctrl[0]) || (q[1] && ctrl[2]));
    pa[19] ^= inv && ((q[2] && ctrl[1]) || (q[1] && ctrl[3]));
    dpQ.push_back('{cyc + 2, ctrl[7] ? io : {8'h00, io[7:0]}, pa, req && !ctrl[4]});
  endtask

  // Checks each completed APB access against the oldest note.
  always @(posedge sys_clk) begin
    iodsc_ap_t e;
    if (psel && penable && pready) begin
      e = apQ.pop_front();
      chk("pslverr", {31'h0, pslverr}, {31'h0, e.err});
      if (e.rd) chk("prdata", prdata, e.d);
    end
  end

  // Checks datapath outputs once they are settled, a cycle after their inputs.
  always @(negedge sys_clk) begin
    cyc++;
    while (dpQ.size() > 0 && dpQ[0].due == cyc) begin
      chk("ioDecodeAddr", {16'h0, ioDec}, {16'h0, dpQ[0].io});
      chk("bankAddr", {12'h0, bankAddr}, {12'h0, dpQ[0].ba});
      chk("chipSelect", {31'h0, cs_n}, {31'h0, dpQ[0].cs});
      void'(dpQ.pop_front());
    end
  end

  // Main sequence: reset state, register edges, then random control and traffic.
  initial begin
    int s;
    void'($urandom(32'hc6209124));
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    apb(1'b0, 12'h010, 32'h0);
    dp(16'hff5a, 20'h9abcd, 3'b101, 1'b1);
    dp(16'h1234, 20'h10000, 3'b011, 1'b0);
    $display("Test reset state done");
    apb(1'b1, 12'h010, 32'hff);
    apb(1'b0, 12'h010, 32'h0);
    apb(1'b1, 12'h014, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    $display("Test register access done");
    repeat (60) begin
      apb(1'b1, 12'h010, $urandom);
      apb(1'b0, 12'h010, 32'h0);
      repeat (6) begin
        s = $urandom_range(2);
        dp(16'($urandom), 20'($urandom), {s == 2, s == 1, 1'($urandom)}, 1'($urandom));
      end
    end
    $display("Test random control done");
    repeat (4) @(posedge sys_clk);
    results();
  end
endmodule
